/* plwo_bridge.v */
// PCI lock tracking, snoop issue and write ordering for the host bridge
`include "plwo_regs.vh"
// What this block does
// - As PCI master the bridge never sets a lock but honours locks of others.
// - The PCI lock pin is only ever an input.
// - On lock establishment the 32-byte block address is stored.
// - Accesses to the locked block from others or the processor are retried until release.
// - The read that begins a lock triggers a write-with-flush snoop on the processor bus.
// - A processor retry of that snoop retries the PCI cycle so modified data is written back.
// - Every PCI access to system memory is presented as a processor-bus snoop, except another master's hit on the locked block, which is retried at once.
// - In 2:1 mode with one processor master target initial latency should stay within 32 PCI clocks; the block only counts snoop waits to 32 and flags it.
// - Processor-to-PCI memory writes are posted and issued on PCI later.
// - A retried posted write is reissued until it completes.
// - A second processor-to-PCI write is stalled until the posted one completes on PCI.
// - Processor-to-PCI I/O writes are posted like memory writes and complete in order before anything later.
// - PCI reads of memory do not wait for posted writes to drain.
module plwo_bridge #(
  parameter AW = 32,
  parameter DW = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // PCI target side, from pins
  input wire pci_lock_n,
  input wire pci_frame_n,
  input wire pci_mem_hit,
  input wire pci_is_read,
  input wire [AW-1:0] pci_addr,
  input wire pci_last,
  // PCI target answers
  output reg pci_tgt_retry_q,
  output reg pci_tgt_go_q,
  // Processor snoop port
  output reg snp_req_q,
  output reg snp_kind_q,
  output reg [AW-1:0] snp_addr_q,
  input wire snp_done,
  input wire snp_cpu_retry,
  // Processor memory access check
  input wire cpu_mem_valid,
  input wire [AW-1:0] cpu_mem_addr,
  output wire cpu_mem_retry,
  // Processor-to-PCI writes
  input wire cpu_wr_valid,
  input wire cpu_wr_io,
  input wire [AW-1:0] cpu_wr_addr,
  input wire [DW-1:0] cpu_wr_data,
  output wire cpu_wr_ready,
  // PCI master engine
  output wire mst_req,
  output wire mst_io,
  output wire [AW-1:0] mst_addr,
  output wire [DW-1:0] mst_data,
  output wire mst_lock_oe,
  input wire mst_done,
  input wire mst_retry,
  // Status
  output reg lock_active_q,
  output wire post_busy,
  output reg til_over_q
);
  localparam S_IDLE = 2'h0;
  localparam S_SNOOP = 2'h1;
  localparam S_DATA = 2'h2;
  localparam S_HOLD = 2'h3;
  localparam [5:0] TIL_LIM = `PLWO_TIL_MAX;

  // Same 32-byte block: low address bits ignored
  function blk_eq;
    input [AW-1:0] a;
    input [AW-1:0] b;
    begin
      blk_eq = (a[AW-1:`PLWO_BLK_LSB] == b[AW-1:`PLWO_BLK_LSB]);
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  reg [1:0] lock_s_q;
  reg [1:0] frame_s_q;
  wire lock_n = lock_s_q[1];
  wire frame_n = frame_s_q[1];
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_s_q <= 2'h3;
      frame_s_q <= 2'h3;
    end else begin
      lock_s_q <= {lock_s_q[0], pci_lock_n};
      frame_s_q <= {frame_s_q[0], pci_frame_n};
    end
  end

  // ==========================================================
  // Lock tracking
  reg [AW-1:0] lock_addr_q;
  reg owner_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg frame_prev_q;
  wire start = frame_prev_q && !frame_n;
  // Ownership judged on this very start, not the registered flag,
  // so a new master is caught in the cycle it appears
  wire owner_now = start ? !lock_n : owner_q;
  // A start with lock high and a held lock is a different master
  wire other_hit = lock_active_q && !owner_now && blk_eq(pci_addr, lock_addr_q);
  // Only a read with the lock pin low can begin a lock
  wire lock_begin = start && pci_mem_hit && pci_is_read && !lock_n && !lock_active_q;
  reg [5:0] til_q;

  // Processor accesses to the locked block bounce
  assign cpu_mem_retry = cpu_mem_valid && lock_active_q && blk_eq(cpu_mem_addr, lock_addr_q);
  // Lock pin never driven by this bridge as master
  assign mst_lock_oe = 1'b0;

  // ==========================================================
  // Target state machine
  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (start && pci_mem_hit) begin
          st_d = other_hit ? S_HOLD : S_SNOOP;
        end
      end
      S_SNOOP: begin
        if (snp_done) begin
          st_d = snp_cpu_retry ? S_HOLD : S_DATA;
        end
      end
      S_DATA: begin
        if (pci_last || frame_n) begin
          st_d = S_IDLE;
        end
      end
      S_HOLD: begin
        if (frame_n) begin
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // ==========================================================
  // Registered answers, snoop request and lock state
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      frame_prev_q <= 1'b1;
      lock_active_q <= 1'b0;
      owner_q <= 1'b0;
      lock_addr_q <= {AW{1'b0}};
      snp_req_q <= 1'b0;
      snp_kind_q <= `PLWO_SNP_PLAIN;
      snp_addr_q <= {AW{1'b0}};
      pci_tgt_retry_q <= 1'b0;
      pci_tgt_go_q <= 1'b0;
      til_q <= 6'h00;
      til_over_q <= 1'b0;
    end else begin
      st_q <= st_d;
      frame_prev_q <= frame_n;
      pci_tgt_retry_q <= (st_d == S_HOLD) && (st_q != S_HOLD);
      pci_tgt_go_q <= (st_d == S_DATA) && (st_q == S_SNOOP);
      if (st_q == S_IDLE && st_d == S_SNOOP) begin
        // Every memory access but another master's locked-block hit snoops; lock start uses flush form
        snp_req_q <= 1'b1;
        snp_kind_q <= lock_begin ? `PLWO_SNP_FLUSH : `PLWO_SNP_PLAIN;
        snp_addr_q <= pci_addr;
      end else if (snp_done) begin
        snp_req_q <= 1'b0;
      end
      // Lock is taken once the flushing read gets data with lock asserted
      if (st_q == S_SNOOP && st_d == S_DATA && snp_kind_q == `PLWO_SNP_FLUSH && !lock_n) begin
        lock_active_q <= 1'b1;
        owner_q <= 1'b1;
        lock_addr_q <= {snp_addr_q[AW-1:`PLWO_BLK_LSB], {`PLWO_BLK_LSB{1'b0}}};
      end else if (lock_active_q && lock_n && frame_n) begin
        // Release: lock and frame both deasserted
        lock_active_q <= 1'b0;
        owner_q <= 1'b0;
        lock_addr_q <= {AW{1'b0}};
      end else if (start && lock_n && lock_active_q) begin
        owner_q <= 1'b0;
      end else if (start && !lock_n && lock_active_q) begin
        owner_q <= 1'b1;
      end
      // Target latency watch; counts snoop wait cycles, saturates at the limit and only flags it
      if (st_q == S_IDLE) begin
        til_q <= 6'h00;
      end else if (st_q == S_SNOOP && til_q != TIL_LIM) begin
        til_q <= til_q + 6'h01;
      end
      til_over_q <= (til_q == TIL_LIM);
    end
  end

  // ==========================================================
  // Processor-to-PCI writes; PCI reads above never wait on this
  wire pb_busy;
  assign post_busy = pb_busy;
  // An I/O write waits for the previous write too, and holds off later ones
  plwo_post_buf #(.AW(AW), .DW(DW)) u_post (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cpu_wr_valid(cpu_wr_valid),
    .cpu_wr_io(cpu_wr_io),
    .cpu_wr_addr(cpu_wr_addr),
    .cpu_wr_data(cpu_wr_data),
    .cpu_wr_ready(cpu_wr_ready),
    .mst_req_q(mst_req),
    .mst_io_q(mst_io),
    .mst_addr_q(mst_addr),
    .mst_data_q(mst_data),
    .mst_done(mst_done),
    .mst_retry(mst_retry),
    .busy(pb_busy)
  );
endmodule // plwo_bridge

/* plwo_regs.vh */
// Constants for the PCI lock and write-ordering bridge logic
`ifndef PLWO_REGS_VH
`define PLWO_REGS_VH
// ==========================================================
// Lock granularity and latency
`define PLWO_BLK_LSB 5
`define PLWO_TIL_MAX 6'h20
// ==========================================================
// Processor-side command codes
`define PLWO_CMD_MEMWR 2'h0
`define PLWO_CMD_IOWR 2'h1
// ==========================================================
// Snoop kinds driven onto the processor bus
`define PLWO_SNP_PLAIN 1'h0
`define PLWO_SNP_FLUSH 1'h1
`endif

/* plwo_post_buf.v */
// Single-entry posted write holder for processor-to-PCI memory and I/O writes
`include "plwo_regs.vh"
module plwo_post_buf #(
  parameter AW = 32,
  parameter DW = 32
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Processor side
  input wire cpu_wr_valid,
  input wire cpu_wr_io,
  input wire [AW-1:0] cpu_wr_addr,
  input wire [DW-1:0] cpu_wr_data,
  output wire cpu_wr_ready,
  // PCI master side
  output reg mst_req_q,
  output reg mst_io_q,
  output reg [AW-1:0] mst_addr_q,
  output reg [DW-1:0] mst_data_q,
  input wire mst_done,
  input wire mst_retry,
  // Status
  output wire busy
);
  reg held_q;
  // ==========================================================
  // Acceptance
  // Only one entry: a second write stalls until PCI completion
  assign cpu_wr_ready = !held_q;
  assign busy = held_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      held_q <= 1'b0;
      mst_req_q <= 1'b0;
      mst_io_q <= 1'b0;
      mst_addr_q <= {AW{1'b0}};
      mst_data_q <= {DW{1'b0}};
    end else if (!held_q) begin
      if (cpu_wr_valid) begin
        // Memory and I/O writes both release the processor at once (posted)
        held_q <= 1'b1;
        mst_req_q <= 1'b1;
        mst_io_q <= cpu_wr_io;
        mst_addr_q <= cpu_wr_addr;
        mst_data_q <= cpu_wr_data;
      end
    end else if (mst_done && !mst_retry) begin
      held_q <= 1'b0;
      mst_req_q <= 1'b0;
    end else begin
      // Retried: request stays up so the write is reissued
      mst_req_q <= 1'b1;
    end
  end
endmodule // plwo_post_buf

/* plwo_checker.sv */
// Port assertions for the lock and write-ordering bridge
module plwo_checker #(parameter AW = 32) (
  // Clock and reset
  input wire core_clk, reset_n,
  // Watched ports
  input wire lock_active_q, mst_lock_oe, cpu_mem_retry, cpu_wr_valid, cpu_wr_ready,
  input wire mst_req, mst_done, mst_retry, snp_req_q, snp_done, snp_cpu_retry, pci_tgt_retry_q,
  input wire [AW-1:0] mst_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Checks
  lock_pin_a: assert property (!mst_lock_oe) else $error("lock pin driven");
  free_pass_a: assert property (!lock_active_q |-> !cpu_mem_retry)
    else $error("stray retry");
  post_stall_a: assert property (mst_req |-> !cpu_wr_ready) else $error("write overtaken");
  post_issue_a: assert property (cpu_wr_valid && cpu_wr_ready |=>
    mst_req && !cpu_wr_ready) else $error("write not issued");
  write_reissue_a: assert property (mst_req && !(mst_done && !mst_retry) |=> mst_req
    && $stable(mst_addr)) else $error("write dropped");
  post_end_a: assert property (mst_req && mst_done && !mst_retry |=> !mst_req)
    else $error("write not retired");
  snoop_hold_a: assert property (snp_req_q && !snp_done |=> snp_req_q)
    else $error("snoop lost");
  dirty_retry_a: assert property (snp_req_q && snp_done && snp_cpu_retry |=>
    pci_tgt_retry_q) else $error("dirty line not retried");
endmodule // plwo_checker
bind plwo_bridge plwo_checker #(.AW(AW)) i_chk (.core_clk, .reset_n, .lock_active_q, .mst_lock_oe,
  .cpu_mem_retry, .cpu_wr_valid, .cpu_wr_ready, .mst_req, .mst_done, .mst_retry, .snp_req_q,
  .snp_done, .snp_cpu_retry, .pci_tgt_retry_q, .mst_addr);

/* plwo_partner.sv */
// Far-side model: processor snoop responder and PCI target for bridge writes
module plwo_partner (
  // Clock, reset and bench commands
  input wire core_clk, reset_n, snp_rty_cmd, slow,
  input wire [1:0] rty_budget,
  // Bridge requests and answers
  input wire snp_req_q, mst_req,
  output reg snp_done, snp_cpu_retry, mst_done, mst_retry
);
  reg [1:0] tries_q;
  reg [2:0] wait_q;
  wire fire = mst_req && !mst_done && &wait_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {snp_done, snp_cpu_retry, mst_done, mst_retry, tries_q, wait_q} <= 9'h0;
    end else begin
      // Slow mode answers once in eight cycles
      wait_q <= slow ? wait_q + 3'h1 : 3'h7;
      // Snoops answered next cycle, as memory at its fastest safe timing
      snp_done <= snp_req_q && !snp_done;
      // Flags mean nothing apart from done, so they wander
      snp_cpu_retry <= (snp_req_q && !snp_done) ? snp_rty_cmd : ~snp_cpu_retry;
      mst_done <= fire;
      mst_retry <= fire ? tries_q < rty_budget : ~mst_retry;
      tries_q <= !mst_req ? 2'h0 : tries_q + {1'b0, mst_done && mst_retry};
    end
  end
endmodule // plwo_partner

/* tb_top.sv */
// Self-checking bench for the lock and write-ordering bridge
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  reg core_clk = 0, reset_n = 0, pci_lock_n = 1, pci_frame_n = 1, pci_mem_hit = 0, pci_is_read = 0;
  reg pci_last = 0, cpu_mem_valid = 0, cpu_wr_valid = 0, cpu_wr_io = 0, snp_rty_cmd = 0, slow = 0;
  reg [1:0] rty_budget = 0;
  reg [31:0] pci_addr = 0, cpu_mem_addr = 0, cpu_wr_addr = 0, cpu_wr_data = 0;
  wire snp_done, snp_cpu_retry, mst_done, mst_retry, pci_tgt_retry_q, pci_tgt_go_q, snp_req_q;
  wire snp_kind_q, cpu_mem_retry, cpu_wr_ready, mst_req, mst_io, mst_lock_oe, lock_active_q;
  wire post_busy, til_over_q;
  wire [31:0] snp_addr_q, mst_addr, mst_data;
  integer failures = 0, check_count = 0, seed = 32'hdca4fac4, n;
  reg [64:0] exp_q[$];
  reg [64:0] e, m;
  always #2.5 core_clk = ~core_clk;
  plwo_bridge i_dut (.*);
  plwo_partner i_far (.*);
  // ==========
  // Checking and closing
  task chk(input [64:0] seen, want);
    check_count = check_count + 1;
    if (seen !== want) begin
      failures = failures + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task final_report;
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded wait: 0 slot free, 1 snoop or refusal, 2 answer, 3 lock gone
  task wt(input integer s);
    #1;
    for (n = 0; !(s == 0 ? cpu_wr_ready : s == 1 ? snp_req_q | pci_tgt_retry_q :
        s == 2 ? pci_tgt_go_q | pci_tgt_retry_q : !lock_active_q); n = n + 1) begin
      @(posedge core_clk);
      #1;
      if (n > 300) begin
        failures = failures + 1;
        final_report;
      end
    end
  endtask
  // ==========
  // Drivers
  task wr(input io, input [1:0] b);
    reg [63:0] v;
    wt(0);
    v = {$random(seed), $random(seed)};
    @(posedge core_clk);
    {cpu_wr_io, cpu_wr_addr, cpu_wr_data, rty_budget} <= {io, v, b};
    cpu_wr_valid <= 1;
    exp_q.push_back({io, v});
    @(posedge core_clk);
    cpu_wr_valid <= 0;
  endtask
  task pa(input lk, rd, sr, xr, la, input [31:0] a);
    @(posedge core_clk);
    {pci_lock_n, pci_is_read, snp_rty_cmd, pci_addr} <= {lk, rd, sr, a};
    // One PCI access at a time, started only as the granted master
    {pci_frame_n, pci_mem_hit} <= 2'b01;
    wt(1);
    if (snp_req_q === 1) begin
      chk(snp_addr_q, a);
      chk(snp_kind_q, !lk && rd);
      wt(2);
    end
    chk(pci_tgt_retry_q, xr);
    @(posedge core_clk);
    {pci_frame_n, pci_last, pci_lock_n} <= {2'b11, la};
    @(posedge core_clk);
    {pci_last, pci_mem_hit} <= 2'b00;
    repeat (4) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    if (reset_n && mst_req && mst_done && !mst_retry) begin
      m = exp_q.size() ? exp_q.pop_front() : 65'bx;
      chk({mst_io, mst_addr, mst_data}, m);
    end
  end
  // ==========
  // Scenarios
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1;
    repeat (3) @(posedge core_clk);
    // Memory and I/O writes back to back, retried at random
    repeat (8) begin
      e = $random(seed);
      wr(e[0], e[2:1]);
    end
    // Read from PCI must not wait for a slow posted write
    slow <= 1;
    wr(0, 3);
    pa(1, 1, 0, 0, 1, 32'h1234_5678);
    chk(post_busy, 1);
    wt(0);
    @(posedge core_clk) slow <= 0;
    pa(0, 1, 1, 1, 1, 32'h0000_1040);
    chk(lock_active_q, 0);
    pa(0, 1, 0, 0, 0, 32'h0000_1040);
    chk(lock_active_q, 1);
    @(posedge core_clk) {cpu_mem_valid, cpu_mem_addr} <= {1'b1, 32'h0000_105c};
    #1 chk(cpu_mem_retry, 1);
    @(posedge core_clk) cpu_mem_addr <= 32'h0000_1060;
    #1 chk(cpu_mem_retry, 0);
    // Another master hits the block, then the lock is dropped
    pa(1, 0, 0, 1, 1, 32'h0000_1044);
    wt(3);
    @(posedge core_clk) cpu_mem_addr <= 32'h0000_1040;
    #1 chk(cpu_mem_retry, 0);
    chk(til_over_q, 0);
    chk(exp_q.size(), 0);
    final_report;
  end
endmodule // tb_top
